// ==== logic/gcw_pin_sync.sv ====
// Two-stage synchroniser for the pin input levels.
// Assumes pins change freely with respect to ref_clk.
`timescale 1ns/1ps
module gcw_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;  // Read by the second stage only

    // Second stage isolates metastability from all consumers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1  <= '0;
            syncOut <= '0;
        end else if (clkEn) begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// ==== logic/gcw_pkg.sv ====
// Constants shared by the upper pin configuration and wake block.
// Assumes a 32-bit Wishbone register bus and an 8-bit byte address.
package gcw_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] UPPER_PIN_CONFIG_OFS  = 8'h1C;
    localparam logic [7:0] PIN_WAKE_POLARITY_OFS = 8'h20;

    // ------------------------------------------------------------
    // Field positions, upper_pin_config
    // ------------------------------------------------------------
    localparam int FUNC_SEL_LSB = 24;
    localparam int DRV_TYPE_LSB = 16;
    localparam int DIR_LSB      = 8;
    localparam int DATA_LSB     = 0;
    localparam int UPPER_W      = 4;

    // ------------------------------------------------------------
    // Field positions, pin_wake_polarity
    // ------------------------------------------------------------
    localparam int POL_LSB  = 16;
    localparam int WAKE_LSB = 0;
    localparam int ALL_W    = 8;

    // ------------------------------------------------------------
    // Image byte order and fixed defaults
    // ------------------------------------------------------------
    localparam int IMG_FUNC = 0;
    localparam int IMG_DRV  = 1;
    localparam int IMG_DIR  = 2;
    localparam int IMG_DATA = 3;
    localparam int IMG_POL  = 4;
    localparam int IMG_WAKE = 5;
    localparam int IMG_W    = 48;
    localparam logic [47:0] FIXED_IMAGE = 48'h0000_0000_00FF;
endpackage

// ==== logic/gcw_upper_cfg_wake.sv ====
// Upper pin configuration and eight-pin wake source block.
// Assumes a classic Wishbone master, pin levels synchronous-free,
// and a default image supplied by the EEPROM/OTP loader.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Function-select bit clear makes pin general purpose
// - Driver bit set push/pull, clear open-drain
// - Direction bit set output, clear input
// - Output pins driven from written data bits
// - Data reads return sampled pin levels
// - Only input pins may raise wake events
// - Wake enable bit lets pin wake device
// - Polarity bit picks low or high trigger
// - Non general purpose pins never wake
// - Protected resets leave all fields untouched
// - Function-select default EEPROM, OTP, else ones
// - USB or lite reset restores loaded image
// - Polarity/wake defaults use the whole image byte, else zero
// - Driver, direction, data default EEPROM, OTP, else zero
module gcw_upper_cfg_wake
    import gcw_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              eepromPresent,
    input  wire logic              otpConfigured,
    input  wire logic [47:0]       eepromImage,
    input  wire logic [47:0]       otpImage,
    input  wire logic              imageLoad,
    input  wire logic              usbReset,
    input  wire logic              liteReset,
    input  wire logic              resetProtect,
    input  wire logic [7:0]        pinIn,
    input  wire logic [3:0]        lowerGpioInput,
    output logic      [3:0]        pinOut,
    output logic      [3:0]        pinOe,
    output logic      [7:0]        pinEvent,
    output logic                   wakeRequest
);
    import gcw_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wr[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Pick one byte out of the default image
    function automatic logic [7:0] imgByte(input logic [47:0] img,
                                           input int          idx);
        return img[8*idx +: 8];
    endfunction

    // Upper nibble of one image byte; bytes 0-3 carry pins 4-7 there
    function automatic logic [3:0] imgNib(input logic [47:0] img,
                                          input int          idx);
        return img[8*idx+4 +: 4];
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [47:0] image;                 // Last loaded default image
    logic [3:0]  pinFunctionSelect;     // 1 = pin owned by other logic
    logic [3:0]  pinDriverType;         // 1 = push/pull
    logic [3:0]  pinDirection;          // 1 = output
    logic [3:0]  pinDataValue;          // Written output data
    logic [7:0]  wakeTriggerPolarity;   // 1 = high level triggers
    logic [7:0]  wakeSourceEnable;      // 1 = may wake the device
    logic [7:0]  pinSync;               // Synchronised pin levels
    logic [47:0] next_image;            // Image chosen at load time
    logic [47:0] restoreImage;          // Image a restore copies from
    logic        restore;               // Unprotected field restore
    logic        busReq;                // New bus access this cycle
    logic        wrCfg;                 // Write strobe, config word
    logic        wrWake;                // Write strobe, wake word
    logic [31:0] cfgWord;               // Current config word image
    logic [31:0] wakeWord;              // Current wake word image
    logic [31:0] cfgMerged;             // Config word after byte merge
    logic [31:0] wakeMerged;            // Wake word after byte merge
    logic [31:0] next_rdData;           // Read answer for this access
    logic [7:0]  wakeQualify;           // Pin is a general purpose input

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    gcw_pin_sync #(
        .WIDTH   (8)
    ) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .asyncIn (pinIn),
        .syncOut (pinSync)
    );

    // ------------------------------------------------------------
    // Default image selection
    // ------------------------------------------------------------

    // EEPROM wins, then OTP, then the fixed constants
    always_comb begin
        if (eepromPresent) begin
            next_image = eepromImage;
        end else if (otpConfigured) begin
            next_image = otpImage;
        end else begin
            next_image = FIXED_IMAGE;
        end
    end

    // Image is held so later resets restore the same values
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            image <= FIXED_IMAGE;
        end else if (clkEn && imageLoad) begin
            image <= next_image;
        end
    end

    // Protection masks both soft resets; power-on reset is not gated
    always_comb begin
        restore = (usbReset | liteReset | imageLoad) & ~resetProtect;
        // A load copies the fresh choice; soft resets reuse the held image,
        // so a source that changed since the last load has no effect
        restoreImage = imageLoad ? next_image : image;
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // A fresh access is one not yet acknowledged
    always_comb begin
        busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        wrCfg  = busReq & wb_we_i & (wb_adr_i == UPPER_PIN_CONFIG_OFS);
        wrWake = busReq & wb_we_i & (wb_adr_i == PIN_WAKE_POLARITY_OFS);
    end

    // Stored words as software sees them, reserved bits zero
    always_comb begin
        cfgWord = '0;
        cfgWord[FUNC_SEL_LSB +: UPPER_W] = pinFunctionSelect;
        cfgWord[DRV_TYPE_LSB +: UPPER_W] = pinDriverType;
        cfgWord[DIR_LSB +: UPPER_W]      = pinDirection;
        cfgWord[DATA_LSB +: UPPER_W]     = pinDataValue;
        wakeWord = '0;
        wakeWord[POL_LSB +: ALL_W]  = wakeTriggerPolarity;
        wakeWord[WAKE_LSB +: ALL_W] = wakeSourceEnable;
        cfgMerged  = merge(cfgWord, wb_dat_i, wb_sel_i);
        wakeMerged = merge(wakeWord, wb_dat_i, wb_sel_i);
    end

    // Read path: data field shows the pins, not the stored value
    always_comb begin
        next_rdData = '0;                              // Unmapped reads zero
        if (wb_adr_i == UPPER_PIN_CONFIG_OFS) begin
            next_rdData = cfgWord;
            next_rdData[DATA_LSB +: UPPER_W] = pinSync[7:4];
        end else if (wb_adr_i == PIN_WAKE_POLARITY_OFS) begin
            next_rdData = wakeWord;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------

    // One wait-free answer per access; ack drops the cycle after
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
        end else if (clkEn) begin
            wb_ack_o <= busReq;
        end
    end

    // Read data captured with the ack, zero otherwise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_dat_o <= '0;
        end else if (clkEn) begin
            if (busReq && !wb_we_i) begin
                wb_dat_o <= next_rdData;
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------

    // Function select; soft reset beats a same-cycle write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinFunctionSelect <= FIXED_IMAGE[8*IMG_FUNC+4 +: 4];
        end else if (clkEn) begin
            if (restore) begin
                // Upper nibble of the function-select byte covers pins 4-7
                pinFunctionSelect <= imgNib(restoreImage, IMG_FUNC);
            end else if (wrCfg) begin
                pinFunctionSelect <= cfgMerged[FUNC_SEL_LSB +: UPPER_W];
            end
        end
    end

    // Driver type
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinDriverType <= FIXED_IMAGE[8*IMG_DRV+4 +: 4];
        end else if (clkEn) begin
            if (restore) begin
                pinDriverType <= imgNib(restoreImage, IMG_DRV);
            end else if (wrCfg) begin
                pinDriverType <= cfgMerged[DRV_TYPE_LSB +: UPPER_W];
            end
        end
    end

    // Direction
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinDirection <= FIXED_IMAGE[8*IMG_DIR+4 +: 4];
        end else if (clkEn) begin
            if (restore) begin
                pinDirection <= imgNib(restoreImage, IMG_DIR);
            end else if (wrCfg) begin
                pinDirection <= cfgMerged[DIR_LSB +: UPPER_W];
            end
        end
    end

    // Output data; meaningless for inputs until written
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinDataValue <= FIXED_IMAGE[8*IMG_DATA+4 +: 4];
        end else if (clkEn) begin
            if (restore) begin
                pinDataValue <= imgNib(restoreImage, IMG_DATA);
            end else if (wrCfg) begin
                pinDataValue <= cfgMerged[DATA_LSB +: UPPER_W];
            end
        end
    end

    // Polarity, all eight pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wakeTriggerPolarity <= FIXED_IMAGE[8*IMG_POL +: 8];
        end else if (clkEn) begin
            if (restore) begin
                wakeTriggerPolarity <= imgByte(restoreImage, IMG_POL);
            end else if (wrWake) begin
                wakeTriggerPolarity <= wakeMerged[POL_LSB +: ALL_W];
            end
        end
    end

    // Wake enable, all eight pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wakeSourceEnable <= FIXED_IMAGE[8*IMG_WAKE +: 8];
        end else if (clkEn) begin
            if (restore) begin
                wakeSourceEnable <= imgByte(restoreImage, IMG_WAKE);
            end else if (wrWake) begin
                wakeSourceEnable <= wakeMerged[WAKE_LSB +: ALL_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------

    // Open-drain only pulls low; a one releases the pin.
    // Pins given to another function are not driven from here.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else if (clkEn) begin
            for (int p = 0; p < 4; p++) begin
                if (pinFunctionSelect[p] || !pinDirection[p]) begin
                    pinOut[p] <= 1'b0;
                    pinOe[p]  <= 1'b0;
                end else if (pinDriverType[p]) begin
                    pinOut[p] <= pinDataValue[p];
                    pinOe[p]  <= 1'b1;
                end else begin
                    pinOut[p] <= 1'b0;
                    pinOe[p]  <= ~pinDataValue[p];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Wake sources
    // ------------------------------------------------------------

    // Upper pins qualify from local fields, lower from their owner
    always_comb begin
        wakeQualify[3:0] = lowerGpioInput;
        wakeQualify[7:4] = ~pinFunctionSelect & ~pinDirection;
    end

    gcw_wake_detect #(
        .WIDTH               (8)
    ) u_wake (
        .ref_clk             (ref_clk),
        .nrst                (nrst),
        .clkEn               (clkEn),
        .pinLevel            (pinSync),
        .isGpioInput         (wakeQualify),
        .wakeTriggerPolarity (wakeTriggerPolarity),
        .wakeSourceEnable    (wakeSourceEnable),
        .pinEvent            (pinEvent),
        .wakeRequest         (wakeRequest)
    );
endmodule

// ==== logic/gcw_wake_detect.sv ====
// Level wake and event detection for all eight pins.
// Assumes synchronised pin levels and qualifiers from the caller.
`timescale 1ns/1ps
module gcw_wake_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] pinLevel,
    input  wire logic [WIDTH-1:0] isGpioInput,
    input  wire logic [WIDTH-1:0] wakeTriggerPolarity,
    input  wire logic [WIDTH-1:0] wakeSourceEnable,
    output logic      [WIDTH-1:0] pinEvent,
    output logic                  wakeRequest
);
    logic [WIDTH-1:0] active;  // Pin sits at its trigger level

    // Polarity 1 means high is active, 0 means low is active
    always_comb begin
        active = ~(pinLevel ^ wakeTriggerPolarity) & isGpioInput;
    end

    // Registered so top outputs come straight from flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinEvent    <= '0;
            wakeRequest <= 1'b0;
        end else if (clkEn) begin
            pinEvent    <= active;
            wakeRequest <= |(active & wakeSourceEnable);
        end
    end
endmodule

// ==== tb/gcw_pin_model.sv ====
// Model of the external pins: resolves each upper wire from both drivers.
// Assumes the far side drives every pin whenever the block does not.
`timescale 1ns/1ps
module gcw_pin_model (
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOe,
    input  wire logic [7:0] extLevel,
    output logic      [7:0] pinLevel
);
    // Block drive wins on the upper pins; elsewhere the far side shows
    always_comb begin
        pinLevel = extLevel;
        for (int i = 0; i < 4; i++) begin
            if (pinOe[i]) begin
                pinLevel[4 + i] = pinOut[i];
            end
        end
    end
endmodule

// ==== tb/gcw_upper_cfg_wake_props.sv ====
// Checker for the upper pin config and wake block.
// Assumes it is bound to gcw_upper_cfg_wake and sees its ports only.
`timescale 1ns/1ps
module gcw_upper_cfg_wake_props
    import gcw_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic              clkEn,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [3:0]        lowerGpioInput,
    input wire logic [3:0]        pinOut,
    input wire logic [3:0]        pinOe,
    input wire logic [7:0]        pinEvent,
    input wire logic              wakeRequest
);
    // ----
    // Bus answer timing
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic rdReq;  // A fresh read request sampled this edge
    assign rdReq = clkEn && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers_req: assert property (
        clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data nonzero outside ack");
    a_unmapped_reads_zero: assert property (rdReq && wb_adr_i != UPPER_PIN_CONFIG_OFS
        && wb_adr_i != PIN_WAKE_POLARITY_OFS |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_reserved_reads_zero: assert property (rdReq |=> (wb_dat_o &
        ($past(wb_adr_i) == UPPER_PIN_CONFIG_OFS ? 32'hF0F0_F0F0 : 32'hFF00_FF00)) == 0)
        else $error("reserved bits read nonzero");

    // ----
    // Pin and wake relations
    // ----
    // Open drain only ever pulls low, so a high output needs push/pull
    a_od_drives_low: assert property ((pinOut & ~pinOe) == 4'h0)
        else $error("pin output high while undriven");
    // Settled drive means an output pin, which may never raise an event
    a_output_no_event: assert property (pinOe == $past(pinOe) && pinOe == $past(pinOe, 2)
        |-> (pinOe & pinEvent[7:4]) == 4'h0)
        else $error("driven pin raised an event");
    a_lower_event_qual: assert property (lowerGpioInput == $past(lowerGpioInput)
        && lowerGpioInput == $past(lowerGpioInput, 2)
        |-> (pinEvent[3:0] & ~lowerGpioInput) == 4'h0)
        else $error("unqualified lower pin raised an event");
    a_wake_needs_event: assert property (wakeRequest |-> pinEvent != 8'h00)
        else $error("wake without any pin event");
endmodule

bind gcw_upper_cfg_wake gcw_upper_cfg_wake_props #(.ADDR_W(ADDR_W)) i_props (
    .ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .lowerGpioInput(lowerGpioInput), .pinOut(pinOut),
    .pinOe(pinOe), .pinEvent(pinEvent), .wakeRequest(wakeRequest));

// ==== tb/gcw_upper_cfg_wake_tb_top.sv ====
// Self-checking bench for the upper pin config and wake block.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module gcw_upper_cfg_wake_tb_top;
    import gcw_pkg::*;
    logic        ref_clk, nrst, wbCyc, wbStb, wbWe, wbAck, wakeReq;
    logic        eepP, otpC, imgLd, usbR, liteR, prot;
    logic [7:0]  wbAdr, extLvl, pinLvl, pinEv, pol, wk;  // Mirror pol/wk
    logic [3:0]  wbSel, lowIn, pinOut, pinOe, func, drv, dir, dat;  // Mirror fields
    logic [31:0] wbDi, wbDo;
    logic [47:0] eepImg, otpImg, latImg;  // latImg mirrors the loaded image
    logic [31:0] expQ[$];                 // Expected read data, oldest first
    int          miscompares, checksDone;

    gcw_upper_cfg_wake i_dut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDi), .wb_dat_o(wbDo), .wb_ack_o(wbAck),
        .eepromPresent(eepP), .otpConfigured(otpC), .eepromImage(eepImg),
        .otpImage(otpImg), .imageLoad(imgLd), .usbReset(usbR), .liteReset(liteR),
        .resetProtect(prot), .pinIn(pinLvl), .lowerGpioInput(lowIn), .pinOut(pinOut),
        .pinOe(pinOe), .pinEvent(pinEv), .wakeRequest(wakeReq));
    gcw_pin_model i_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLvl),
        .pinLevel(pinLvl));

    // ----
    // Helpers
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checksDone++;
        if (e !== s) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Wire levels as the pins should show them, from the mirrored fields
    function automatic logic [7:0] lvl();
        logic [7:0] v;
        v = extLvl;
        for (int i = 0; i < 4; i++) begin
            if (!func[i] && dir[i] && (drv[i] || !dat[i])) v[4 + i] = drv[i] & dat[i];
        end
        return v;
    endfunction
    // One classic cycle; the master waits on ack, then idles a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int t;
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w; wbAdr <= a; wbDi <= d; wbSel <= s;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while (wbAck !== 1'b1 && t < 50);
        if (wbAck !== 1'b1) chk("ack", 32'h1, 32'h0);
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wb(1'b1, a, d, s);
        if (a == UPPER_PIN_CONFIG_OFS) begin
            if (s[3]) func = d[27:24];
            if (s[2]) drv = d[19:16];
            if (s[1]) dir = d[11:8];
            if (s[0]) dat = d[3:0];
        end else if (a == PIN_WAKE_POLARITY_OFS) begin
            if (s[2]) pol = d[23:16];
            if (s[0]) wk = d[7:0];
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] l;
        l = lvl();
        expQ.push_back(a == UPPER_PIN_CONFIG_OFS ?
            {4'h0, func, 4'h0, drv, 4'h0, dir, 4'h0, l[7:4]} :
            a == PIN_WAKE_POLARITY_OFS ? {8'h00, pol, 8'h00, wk} : 32'h0000_0000);
        wb(1'b0, a, $urandom(), 4'hF);
    endtask
    task automatic chk_pins();
        logic [7:0] ev;
        ev = {~func & ~dir, lowIn} & ~(lvl() ^ pol);
        chk("pinOe", 32'(~func & dir & (drv | ~dat)), 32'(pinOe));
        chk("pinOut", 32'(~func & dir & drv & dat), 32'(pinOut));
        chk("pinEvent", 32'(ev), 32'(pinEv));
        chk("wakeReq", 32'(|(ev & wk)), 32'(wakeReq));
    endtask
    // Restore source k: 0 image load, 1 USB reset, 2 lite reset
    task automatic restore(input int k);
        if (k == 0) imgLd <= 1'b1; else if (k == 1) usbR <= 1'b1; else liteR <= 1'b1;
        @(posedge ref_clk);
        imgLd <= 1'b0; usbR <= 1'b0; liteR <= 1'b0;
        // A load latches the image even while restores are protected
        if (k == 0) latImg = eepP ? eepImg : otpC ? otpImg : FIXED_IMAGE;
        if (!prot) begin
            {wk, pol, dat, dir, drv, func} = {latImg[47:32], latImg[31:28],
                latImg[23:20], latImg[15:12], latImg[7:4]};
        end
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----
    // Read monitor and watchdog
    // ----
    always @(posedge ref_clk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            if (expQ.size() == 0) chk("readQueue", 32'h0, 32'h1);
            else chk("readData", expQ.pop_front(), wbDo);
        end
    end
    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end

    // ----
    // Scenarios
    // ----
    initial begin
        {nrst, wbCyc, wbStb, wbWe, eepP, otpC, imgLd, usbR, liteR, prot} = '0;
        {wbAdr, wbSel, wbDi, eepImg, otpImg, lowIn, drv, dir, dat, pol, wk} = '0;
        extLvl = 8'hA5; func = 4'hF; latImg = FIXED_IMAGE;
        miscompares = 0; checksDone = 0;
        void'($urandom(81));
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(UPPER_PIN_CONFIG_OFS);
        rd(PIN_WAKE_POLARITY_OFS);
        chk_pins();
        $display("test reset defaults done");
        repeat (8) begin
            wr(UPPER_PIN_CONFIG_OFS, $urandom(), 4'hF);
            extLvl <= 8'($urandom());
            repeat (5) @(posedge ref_clk);
            chk_pins();
            rd(UPPER_PIN_CONFIG_OFS);
        end
        wr(UPPER_PIN_CONFIG_OFS, 32'hFFFF_FFFF, 4'b0001);
        wr(8'h24, 32'hFFFF_FFFF, 4'hF);
        rd(8'h24);
        rd(UPPER_PIN_CONFIG_OFS);
        $display("test config and lanes done");
        wr(UPPER_PIN_CONFIG_OFS, 32'h0000_0000, 4'hF);
        repeat (10) begin
            lowIn <= 4'($urandom());
            wr(PIN_WAKE_POLARITY_OFS, $urandom(), 4'hF);
            extLvl <= 8'($urandom());
            repeat (5) @(posedge ref_clk);
            chk_pins();
            rd(PIN_WAKE_POLARITY_OFS);
        end
        wr(UPPER_PIN_CONFIG_OFS, 32'h0A00_0500, 4'hF);
        repeat (5) @(posedge ref_clk);
        chk_pins();
        $display("test wake sources done");
        otpC <= 1'b1; otpImg <= {$urandom(), 16'($urandom())};
        restore(0);
        rd(UPPER_PIN_CONFIG_OFS);
        rd(PIN_WAKE_POLARITY_OFS);
        eepP <= 1'b1; eepImg <= {$urandom(), 16'($urandom())};
        restore(0);
        chk_pins();
        for (int k = 0; k < 4; k++) begin
            wr(UPPER_PIN_CONFIG_OFS, $urandom(), 4'hF);
            wr(PIN_WAKE_POLARITY_OFS, $urandom(), 4'hF);
            prot <= (k < 2);
            eepImg <= {$urandom(), 16'($urandom())};  // soft resets use the held image
            restore(1 + k % 2);
            rd(UPPER_PIN_CONFIG_OFS);
            rd(PIN_WAKE_POLARITY_OFS);
        end
        eepP <= 1'b0; otpC <= 1'b0;
        restore(0);
        rd(UPPER_PIN_CONFIG_OFS);
        rd(PIN_WAKE_POLARITY_OFS);
        $display("test restore sources done");
        give_verdict();
    end
endmodule
